/* hw/rod_motion_pkg.sv */
package rod_motion_pkg;
   // rods handled by this block, and rod index width
   localparam int NUM_RODS = 4;
   localparam int ROD_W = 2;
   // step position scale: full-in is 0, full-out is 200 steps
   localparam logic [7:0] POS_FULL_IN = 8'h00;
   localparam logic [7:0] POS_FULL_OUT = 8'hC8;
   localparam logic [7:0] POS_TEST_MAX = 8'hFF;
   localparam logic [7:0] POS_RST = 8'h00;
   localparam logic [7:0] STEP_ONE = 8'h01;
   localparam logic [7:0] NOTCH_STEPS = 8'h04;
   // one step is 18.3 mm of travel, in micrometres
   localparam int STEP_UM = 18300;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int STEP_TIME_NS = 2000;
   localparam int BRAKE_LEAD_NS = 400;
   localparam logic [8:0] STEP_CYC =
      9'((STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] BRAKE_CYC =
      9'((BRAKE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_GANG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_POS_BASE = 8'h10;
   // control register fields and reset values
   localparam int CTRL_TEST_BIT = 0;
   localparam int CTRL_BYP_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [3:0] GANG_RST = 4'hF;
   // status register fields
   localparam int ST_SEL_BIT = 0;
   localparam int ST_BLK_BIT = 1;
   localparam int ST_MIS_BIT = 2;
   localparam int ST_MOV_BIT = 3;
   localparam int ST_DIR_BIT = 4;
   localparam int ST_MODE_LSB = 5;

   typedef enum logic [1:0] {
      MODE_STEP,
      MODE_NOTCH,
      MODE_CONT
   } move_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BRAKE,
      ST_MOVE
   } run_state_t;
endpackage

/* hw/rod_step_motion_control.sv */
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module rod_step_motion_control
   import rod_motion_pkg::*;
(
   input wire logic ref_clk_i, // 125 MHz clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic [7:0] addr_i, // register byte address
   input wire logic [31:0] wdata_i, // register write data
   input wire logic wr_i, // register write strobe
   input wire logic rd_i, // register read strobe
   output logic [31:0] rdata_o, // read data, cycle after rd_i
   input wire logic dir_touch_i, // direction selector touch
   input wire logic mode_touch_i, // movement mode selector touch
   input wire logic single_touch_i, // single-rod control touch
   input wire logic withdraw_pb_i, // withdraw pushbutton level
   input wire logic insert_pb_i, // insert pushbutton level
   input wire logic cmd_load_i, // command copies valid pulse
   input wire logic [1:0] cmd_a_rod_i, // channel A copy, rod index
   input wire logic cmd_a_gang_i, // channel A copy, gang flag
   input wire logic [1:0] cmd_b_rod_i, // channel B copy, rod index
   input wire logic cmd_b_gang_i, // channel B copy, gang flag
   input wire logic thermal_limit_blk_i, // thermal limit monitor block
   input wire logic rod_worth_blk_i, // rod worth minimizer block
   input wire logic startup_nm_blk_i, // startup neutron monitor block
   input wire logic avg_power_blk_i, // average power monitor block
   input wire logic [3:0] separation_i, // rod drive separation per rod
   input wire logic [3:0] rod_operable_i, // rod operable per rod
   input wire logic alt_insert_a_i, // insertion/scram-follow, chan A
   input wire logic alt_insert_b_i, // insertion/scram-follow, chan B
   input wire logic [11:0] synchro_a_i, // synchro A digitised angle
   input wire logic [11:0] synchro_b_i, // synchro B digitised angle
   output logic cmd_dir_out_o, // selected direction, 1 = out
   output logic [1:0] cmd_mode_o, // selected movement mode
   output logic stop_req_o, // motion stop request pulse
   output logic rod_block_o, // rod block toward server module
   output logic motion_inhibit_o, // command copy mismatch
   output logic [3:0] chan_a_step_o, // step command, channel A
   output logic [3:0] chan_b_step_o, // step command, channel B
   output logic chan_dir_o, // step direction, 1 = withdraw
   output logic [3:0] motor_step_o, // voted motor step pulse
   output logic brake_release_o, // voted brake release
   output logic [11:0] abs_pos_o, // absolute position from synchros
   output logic [7:0] disp_pos_o, // shown step position
   output logic [3:0] disp_bright_o, // 1 full, 0 half brightness
   output logic moving_o // movement in progress
);

   logic test_mode;
   logic bypass;
   logic [3:0] gang_mask;
   logic sel_valid;
   logic sel_gang;
   logic [ROD_W-1:0] sel_rod;
   logic mismatch;
   logic wd_q;
   logic in_q;
   logic run_out;
   logic run_cont;
   logic [3:0] run_mask;
   logic [8:0] tmr;
   logic brake_a;
   logic brake_b;
   logic [7:0] pos [NUM_RODS];
   logic [7:0] tgt [NUM_RODS];
   move_mode_t mode;
   run_state_t state;
   logic [3:0] sel_mask;
   logic [3:0] need;
   logic blk;
   logic start_w;
   logic start_i;
   logic start_ok;
   logic pb_held;
   logic all_done;
   logic tick;
   logic copies_agree;

   // clamp a signed step value into the travel allowed now
   function automatic logic [7:0] clamp_pos(input logic signed [9:0] v,
                                            input logic tm);
      logic signed [9:0] hi;
      hi = $signed({2'h0, tm ? POS_TEST_MAX : POS_FULL_OUT});
      if (v < $signed({2'h0, POS_FULL_IN})) begin
         clamp_pos = POS_FULL_IN;
      end else if (v > hi) begin
         clamp_pos = hi[7:0];
      end else begin
         clamp_pos = v[7:0];
      end
   endfunction

   // position moved by d steps in the given direction
   function automatic logic signed [9:0] offs(input logic [7:0] p,
                                              input logic out,
                                              input logic [7:0] d);
      if (out) begin
         offs = $signed({2'h0, p}) + $signed({2'h0, d});
      end else begin
         offs = $signed({2'h0, p}) - $signed({2'h0, d});
      end
   endfunction

   // next four-step boundary beyond p in the given direction
   function automatic logic signed [9:0] notch_tgt(input logic [7:0] p,
                                                   input logic out);
      logic [7:0] base;
      base = {p[7:2], 2'h0};
      if (out) begin
         notch_tgt = offs(base, 1'b1, NOTCH_STEPS);
      end else if (p[1:0] != 2'h0) begin
         notch_tgt = $signed({2'h0, base});
      end else begin
         notch_tgt = offs(base, 1'b0, NOTCH_STEPS);
      end
   endfunction

   // rods taking part: one rod or the gang, operable ones only
   assign sel_mask = !sel_valid ? 4'h0 :
      ((sel_gang ? gang_mask : 4'(4'h1 << sel_rod)) & rod_operable_i);
   assign copies_agree = (cmd_a_rod_i == cmd_b_rod_i) &&
                         (cmd_a_gang_i == cmd_b_gang_i);
   // any block source stops motion
   assign blk = thermal_limit_blk_i | rod_worth_blk_i |
                startup_nm_blk_i | avg_power_blk_i |
                (|(separation_i & sel_mask)) |
                (mismatch & ~bypass);
   assign start_w = withdraw_pb_i & ~wd_q;
   assign start_i = insert_pb_i & ~in_q & ~withdraw_pb_i;
   // a new movement only starts when nothing blocks it
   assign start_ok = (state == ST_IDLE) && (start_w || start_i) &&
                     !blk && (sel_mask != 4'h0);
   assign pb_held = run_out ? withdraw_pb_i : insert_pb_i;
   always_comb begin
      for (int i = 0; i < NUM_RODS; i++) begin
         need[i] = run_mask[i] && (pos[i] != tgt[i]);
      end
   end
   assign all_done = (need == 4'h0);
   assign tick = (state == ST_MOVE) && (tmr == 9'h000) && !blk && !all_done;

   // register writes: test mode, bypass and gang membership
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         test_mode <= CTRL_RST[CTRL_TEST_BIT];
         bypass <= CTRL_RST[CTRL_BYP_BIT];
         gang_mask <= GANG_RST;
      end else if (wr_i) begin
         if (addr_i == REG_CTRL) begin
            test_mode <= wdata_i[CTRL_TEST_BIT];
            bypass <= wdata_i[CTRL_BYP_BIT];
         end else if (addr_i == REG_GANG) begin
            gang_mask <= wdata_i[3:0];
         end
      end
   end

   // register reads; unmapped addresses read zero
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         rdata_o <= 32'h0000_0000;
         if (addr_i == REG_CTRL) begin
            rdata_o[CTRL_TEST_BIT] <= test_mode;
            rdata_o[CTRL_BYP_BIT] <= bypass;
         end else if (addr_i == REG_GANG) begin
            rdata_o[3:0] <= gang_mask;
         end else if (addr_i == REG_STATUS) begin
            rdata_o[ST_SEL_BIT] <= sel_valid;
            rdata_o[ST_BLK_BIT] <= blk;
            rdata_o[ST_MIS_BIT] <= mismatch;
            rdata_o[ST_MOV_BIT] <= (state != ST_IDLE);
            rdata_o[ST_DIR_BIT] <= cmd_dir_out_o;
            rdata_o[ST_MODE_LSB +: 2] <= mode;
         end else if (addr_i[7:4] == REG_POS_BASE[7:4] &&
                      addr_i[1:0] == 2'h0) begin
            rdata_o[7:0] <= pos[addr_i[3:2]];
         end
      end
   end

   // command selector: direction toggles, mode cycles
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_dir_out_o <= 1'b0;
         mode <= MODE_STEP;
      end else begin
         if (dir_touch_i) begin
            cmd_dir_out_o <= ~cmd_dir_out_o;
         end
         if (mode_touch_i) begin
            case (mode)
               MODE_STEP: mode <= MODE_NOTCH;
               MODE_NOTCH: mode <= MODE_CONT;
               MODE_CONT: mode <= MODE_STEP;
               default: mode <= MODE_STEP;
            endcase
         end
      end
   end
   assign cmd_mode_o = mode;

   // selection from the two command copies; a mismatch inhibits motion
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_valid <= 1'b0;
         sel_gang <= 1'b0;
         sel_rod <= '0;
         mismatch <= 1'b0;
         stop_req_o <= 1'b0;
      end else begin
         stop_req_o <= single_touch_i && sel_valid && !cmd_load_i;
         if (cmd_load_i) begin
            // both copies must agree before a rod is taken up
            mismatch <= !copies_agree;
            sel_valid <= copies_agree;
            sel_rod <= cmd_a_rod_i;
            sel_gang <= cmd_a_gang_i;
         end else if (single_touch_i && sel_valid) begin
            sel_valid <= 1'b0;
         end
      end
   end
   assign motion_inhibit_o = mismatch;

   // pushbutton history for press detection
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wd_q <= 1'b0;
         in_q <= 1'b0;
      end else begin
         wd_q <= withdraw_pb_i;
         in_q <= insert_pb_i;
      end
   end

   // run sequencer: brake lead, then timed steps until targets reached
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         tmr <= 9'h000;
         run_mask <= 4'h0;
         run_out <= 1'b0;
         run_cont <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_ok) begin
                  run_mask <= sel_mask;
                  run_out <= start_w;
                  run_cont <= (mode == MODE_CONT);
                  tmr <= BRAKE_CYC;
                  state <= ST_BRAKE;
               end
            end
            ST_BRAKE: begin
               if (blk) begin
                  state <= ST_IDLE;
               end else if (tmr == 9'h000) begin
                  tmr <= STEP_CYC;
                  state <= ST_MOVE;
               end else begin
                  tmr <= tmr - 9'h001;
               end
            end
            ST_MOVE: begin
               if (blk || all_done) begin
                  state <= ST_IDLE;
               end else if (tmr == 9'h000) begin
                  tmr <= STEP_CYC;
               end else begin
                  tmr <= tmr - 9'h001;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   assign moving_o = (state != ST_IDLE);
   assign chan_dir_o = run_out;

   // targets: set at start, advanced in continuous, frozen or halted
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_RODS; i++) begin
            tgt[i] <= POS_RST;
         end
      end else begin
         for (int i = 0; i < NUM_RODS; i++) begin
            if (start_ok && sel_mask[i]) begin
               if (mode == MODE_STEP) begin
                  tgt[i] <= clamp_pos(offs(pos[i], start_w, STEP_ONE),
                                      test_mode);
               end else begin
                  tgt[i] <= clamp_pos(notch_tgt(pos[i], start_w),
                                      test_mode);
               end
            end else if (blk && state != ST_IDLE) begin
               tgt[i] <= pos[i];
            end else if (tick && need[i] && run_cont && pb_held) begin
               // four steps ahead of the position after this step
               tgt[i] <= clamp_pos(offs(clamp_pos(
                  offs(pos[i], run_out, STEP_ONE), test_mode),
                  run_out, NOTCH_STEPS), test_mode);
            end
         end
      end
   end

   // step position counter, one count per completed step
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_RODS; i++) begin
            pos[i] <= POS_RST;
         end
      end else begin
         for (int i = 0; i < NUM_RODS; i++) begin
            if (tick && need[i]) begin
               pos[i] <= clamp_pos(offs(pos[i], run_out, STEP_ONE),
                                   test_mode);
            end
         end
      end
   end

   // per-channel commands; the inverter and brake vote two of two
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chan_a_step_o <= 4'h0;
         chan_b_step_o <= 4'h0;
         motor_step_o <= 4'h0;
         brake_a <= 1'b0;
         brake_b <= 1'b0;
         brake_release_o <= 1'b0;
         rod_block_o <= 1'b0;
      end else begin
         chan_a_step_o <= tick ? need : 4'h0;
         chan_b_step_o <= tick ? need : 4'h0;
         motor_step_o <= chan_a_step_o & chan_b_step_o;
         brake_a <= (state != ST_IDLE);
         brake_b <= (state != ST_IDLE);
         // one channel is enough for emergency insertion paths
         brake_release_o <= (brake_a & brake_b) |
                            alt_insert_a_i | alt_insert_b_i;
         rod_block_o <= blk;
      end
   end

   // synchro pair averaged into one absolute position word
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         abs_pos_o <= 12'h000;
      end else begin
         abs_pos_o <= 12'(({1'b0, synchro_a_i} +
                           {1'b0, synchro_b_i}) >> 1);
      end
   end

   // display: selected position held, all other rods dimmed
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         disp_pos_o <= 8'h00;
         disp_bright_o <= 4'hF;
      end else begin
         disp_pos_o <= sel_valid ? pos[sel_rod] : 8'h00;
         disp_bright_o <= sel_valid ? 4'(4'h1 << sel_rod) : 4'hF;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_step_one: assert property (tick && need[0] |=>
      (pos[0] == 8'($past(pos[0]) + 8'h01)) ||
      (pos[0] == 8'($past(pos[0]) - 8'h01)))
      else $error("rod did not move exactly one step");
   a_travel_limit: assert property (!test_mode &&
      $past(!test_mode) |-> pos[0] <= POS_FULL_OUT)
      else $error("rod passed full-out outside test mode");
   a_notch_bound: assert property (start_ok && sel_mask[0] &&
      mode == MODE_NOTCH |=> tgt[0][1:0] == 2'h0)
      else $error("notch target not on a four-step boundary");
   a_cont_ahead: assert property (tick && need[0] && run_cont &&
      pb_held && !test_mode && pos[0] < 8'hC0 && run_out |=>
      tgt[0] == 8'(pos[0] + 8'h04))
      else $error("continuous target not four steps ahead");
   a_target_freeze: assert property (state == ST_MOVE &&
      !pb_held && !blk |=> tgt[0] == $past(tgt[0]))
      else $error("target moved after button release");
   a_block_halt: assert property (blk && state != ST_IDLE |=>
      state == ST_IDLE ##1 chan_a_step_o == 4'h0)
      else $error("movement continued under rod block");
   a_mismatch_block: assert property (mismatch && !bypass
      |=> rod_block_o)
      else $error("channel disagreement did not block");
   a_ext_block: assert property (thermal_limit_blk_i ||
      avg_power_blk_i |=> rod_block_o)
      else $error("external block not raised");
   a_both_chan: assert property (chan_a_step_o == chan_b_step_o)
      else $error("channel commands differ");
   a_motor_vote: assert property (chan_a_step_o[0] &&
      chan_b_step_o[0] |=> motor_step_o[0])
      else $error("agreed command did not drive motor");
   a_brake_first: assert property (|chan_a_step_o |->
      brake_release_o)
      else $error("stepping while brake engaged");
   a_dir_toggle: assert property (dir_touch_i |=>
      cmd_dir_out_o != $past(cmd_dir_out_o))
      else $error("direction did not toggle");
   a_stop_request: assert property (single_touch_i && sel_valid &&
      !cmd_load_i |=> stop_req_o && !sel_valid)
      else $error("second touch did not stop");
   a_copy_inhibit: assert property (cmd_load_i &&
      !copies_agree |=> motion_inhibit_o ##1 rod_block_o || bypass)
      else $error("copy mismatch not inhibited");
   a_alt_brake: assert property (alt_insert_a_i || alt_insert_b_i |=>
      brake_release_o)
      else $error("emergency insertion did not release brake");

   c_notch_done: cover property (state == ST_MOVE && run_mask != 4'h0
      && !run_cont ##1 state == ST_IDLE);
   c_cont_run: cover property (tick && run_cont && pb_held);
   c_block_halt: cover property (blk && state == ST_MOVE);
   c_gang_run: cover property (start_ok && sel_gang);

endmodule // rod_step_motion_control

/* testbench/panel_model.sv */
`timescale 1ns/1ps
// operator panel and plant computer: one stored command, sent as two copies
module panel_model (
   input wire logic clk_i, // bench clock
   input wire logic go_i, // send the stored command
   input wire logic [1:0] rod_i, // selected rod
   input wire logic skew_i, // corrupt copy b on purpose
   input wire logic gang_i, // gang flag for both copies
   output logic load_o, // copies valid pulse
   output logic [1:0] a_rod_o, // copy a, rod
   output logic a_gang_o, // copy a, gang flag
   output logic [1:0] b_rod_o, // copy b, rod
   output logic b_gang_o // copy b, gang flag
);
   // copies launch together; idle copies flip so stale data never looks valid
   always_ff @(posedge clk_i) begin
      load_o <= go_i;
      a_rod_o <= go_i ? rod_i : ~a_rod_o;
      b_rod_o <= go_i ? rod_i ^ {1'b0, skew_i} : ~b_rod_o;
      a_gang_o <= go_i ? gang_i : ~a_gang_o;
      b_gang_o <= go_i ? gang_i : ~b_gang_o;
   end
endmodule // panel_model

/* testbench/rod_step_motion_control_bench.sv */
`timescale 1ns/1ps
module rod_step_motion_control_bench;
   import rod_motion_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, go = 0, skew = 0, rd_d = 0;
   logic gang = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [2:0] touch = 3'h0;
   logic [1:0] pb = 2'h0, alt_ins = 2'h0, rsel = 2'h0;
   logic [3:0] blk = 4'h0, sep = 4'h0, opr = 4'hF, oh;
   logic [11:0] sa = 12'h000, sb = 12'h000;
   logic ld, ag, bg;
   logic [1:0] ar, br;
   logic [31:0] exp_q[$];
   int checks = 0, n_mismatch = 0, r;
   logic [31:0] rdata_o, ca, cb, ms;
   logic dir_o, blk_o, inh, brk, cdir, mov, stop;
   logic [1:0] mode_o;
   logic [11:0] absp;
   logic [7:0] disp;
   logic [3:0] bright;
   always #4 clk = ~clk;
   panel_model i_panel (.clk_i(clk), .go_i(go), .rod_i(rsel), .skew_i(skew),
      .gang_i(gang), .load_o(ld), .a_rod_o(ar), .a_gang_o(ag), .b_rod_o(br),
      .b_gang_o(bg));
   rod_step_motion_control i_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o),
      .dir_touch_i(touch[0]), .mode_touch_i(touch[1]),
      .single_touch_i(touch[2]), .withdraw_pb_i(pb[0]), .insert_pb_i(pb[1]),
      .cmd_load_i(ld), .cmd_a_rod_i(ar), .cmd_a_gang_i(ag), .cmd_b_rod_i(br),
      .cmd_b_gang_i(bg), .thermal_limit_blk_i(blk[0]),
      .rod_worth_blk_i(blk[1]), .startup_nm_blk_i(blk[2]),
      .avg_power_blk_i(blk[3]), .separation_i(sep), .rod_operable_i(opr),
      .alt_insert_a_i(alt_ins[0]), .alt_insert_b_i(alt_ins[1]),
      .synchro_a_i(sa), .synchro_b_i(sb),
      .cmd_dir_out_o(dir_o), .cmd_mode_o(mode_o), .stop_req_o(stop),
      .rod_block_o(blk_o), .motion_inhibit_o(inh), .chan_a_step_o(ca[3:0]),
      .chan_b_step_o(cb[3:0]), .chan_dir_o(cdir), .motor_step_o(ms[3:0]),
      .brake_release_o(brk), .abs_pos_o(absp), .disp_pos_o(disp),
      .disp_bright_o(bright), .moving_o(mov));
   assign ca[31:4] = 28'h0, cb[31:4] = 28'h0, ms[31:4] = 28'h0;
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // read answers are matched against the oldest noted expectation
   always @(posedge clk) begin
      rd_d <= rd;
      if (rd_d) chk("rdata", rdata_o, exp_q.pop_front());
   end
   task automatic rd_reg(logic [7:0] a, logic [31:0] e);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr_reg(logic [7:0] a, logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // ends just past the edge that takes the touch, so callers can look
   task automatic pulse(int i);
      touch[i] <= 1'b1;
      @(posedge clk);
      touch[i] <= 1'b0;
      #1;
   endtask
   task automatic load(logic bad);
      go <= 1'b1;
      skew <= bad;
      @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic wait_step(logic ins, int pos);
      int n;
      n = 0;
      while (ca[3:0] === 4'h0 && n < 1000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 1000) begin
         n_mismatch++;
         close_out();
      end
      chk("chan_a", ca, oh);
      chk("chan_b", cb, oh);
      chk("chan_dir", cdir, !ins);
      chk("moving", mov, 1);
      chk("brake", brk, 1);
      @(posedge clk);
      #1;
      chk("motor", ms, oh);
      chk("disp", disp, pos);
      @(posedge clk);
   endtask
   // no step may appear for n cycles
   task automatic quiet(int n);
      int k;
      k = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (ca[3:0] !== 4'h0) k++;
      end
      chk("extra_steps", k, 0);
      chk("brake_idle", brk, 0);
      chk("moving", mov, 0);
      @(posedge clk);
   endtask
   // rel < 0 lets the button go at once; otherwise at that position
   task automatic move(logic ins, int p0, int p1, int rel);
      int p;
      pb <= ins ? 2'b10 : 2'b01;
      @(posedge clk);
      if (rel < 0) pb <= 2'b00;
      p = p0;
      while (p != p1) begin
         p = ins ? p - 1 : p + 1;
         wait_step(ins, p);
         if (p == rel) pb <= 2'b00;
      end
      quiet(600);
   endtask
   initial begin
      void'($urandom(65));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_reg(REG_CTRL, 0);
      rd_reg(REG_GANG, 32'(GANG_RST));
      rd_reg(REG_STATUS, 0);
      rd_reg(8'h40, 0);
      wr_reg(8'h44, $urandom);
      wr_reg(REG_GANG, 32'h3);
      rd_reg(REG_GANG, 32'h3);
      $display("test registers done");
      for (int i = 1; i <= 3; i++) begin
         pulse(1);
         chk("mode", mode_o, i % 3);
      end
      pulse(0);
      chk("dir", dir_o, 1);
      @(posedge clk);
      $display("test selector done");
      r = $urandom % 4;
      rsel <= 2'(r);
      oh = 4'h1 << r;
      load(1'b1);
      chk("inhibit", inh, 1);
      chk("block", blk_o, 1);
      @(posedge clk);
      wr_reg(REG_CTRL, 32'h3);
      rd_reg(REG_CTRL, 32'h3);
      chk("bypass_blk", blk_o, 0);
      load(1'b1);
      chk("bypass_inh", inh, 1);
      chk("bypass_blk", blk_o, 0);
      @(posedge clk);
      wr_reg(REG_CTRL, 32'h0);
      load(1'b0);
      chk("inhibit", inh, 0);
      chk("bright", bright, oh);
      sa <= 12'($urandom);
      sb <= 12'($urandom);
      @(posedge clk);
      @(posedge clk);
      #1;
      chk("abs", absp, (13'(sa) + 13'(sb)) >> 1);
      @(posedge clk);
      move(1'b0, 0, 1, -1);
      pulse(1);
      @(posedge clk);
      move(1'b0, 1, 4, -1);
      move(1'b1, 4, 0, -1);
      move(1'b1, 0, 0, -1);
      pulse(1);
      @(posedge clk);
      move(1'b0, 0, 6, 2);
      rd_reg(REG_POS_BASE + 8'(4 * r), 6);
      $display("test movement done");
      for (int i = 0; i < 5; i++) begin
         if (i < 4) blk[i] <= 1'b1;
         else sep <= oh;
         repeat (3) @(posedge clk);
         #1;
         chk("block_src", blk_o, 1);
         @(posedge clk);
         if (i == 0) move(1'b0, 6, 6, -1);
         blk <= 4'h0;
         sep <= 4'h0;
         @(posedge clk);
      end
      $display("test block done");
      wr_reg(REG_GANG, 32'hF);
      gang <= 1'b1;
      load(1'b0);
      pulse(1);
      // one rod of the gang made inoperable; the rest step together
      oh = ~(4'h1 << ((r + 1) % 4));
      opr <= oh;
      @(posedge clk);
      move(1'b0, 6, 7, -1);
      $display("test gang done");
      pulse(2);
      chk("stop", stop, 1);
      @(posedge clk);
      #1;
      chk("stop_end", stop, 0);
      chk("bright", bright, 4'hF);
      alt_ins <= 2'($urandom % 3 + 1);
      repeat (2) @(posedge clk);
      #1;
      chk("alt_brake", brk, 1);
      alt_ins <= 2'h0;
      $display("test stop done");
      close_out();
   end
endmodule // rod_step_motion_control_bench
